// File: rtl/motor_pin_device_config_regs.v
// Behaviour
// [RL1] in fault, speed pulse keeps last, forces high or forces low per field
// [RL2] mode 3: pulse runs until back-emf below threshold chosen by pulse source
// [RL3] brake source: pin, forced brake/align per mode bit, or never brake
// [RL4] align brake angle: last commutation angle, or configured alignment angle
// [RL5] speed command from analog, duty, digital value or frequency
// [RL6] device config one at index a6, reset to all zero
// [RL7] unlock key field always reads zero
// [RL8] reserved bits ignore writes and read zero
`timescale 1ns/1ps
`include "pin_cfg_defines.vh"

module motor_pin_device_config_regs #(
	parameter W           = 16,
	parameter DEFAULT_THR = 16'h0100
) (
	// clock and reset
	input  wire         i_core_clk,
	input  wire         i_rst,
	// axi4-lite write address
	input  wire         i_s_awvalid,
	input  wire [11:0]  i_s_awaddr,
	output reg          o_s_awready,
	// axi4-lite write data
	input  wire         i_s_wvalid,
	input  wire [31:0]  i_s_wdata,
	input  wire [3:0]   i_s_wstrb,
	output reg          o_s_wready,
	// axi4-lite write response
	output reg          o_s_bvalid,
	output reg  [1:0]   o_s_bresp,
	input  wire         i_s_bready,
	// axi4-lite read
	input  wire         i_s_arvalid,
	input  wire [11:0]  i_s_araddr,
	output reg          o_s_arready,
	output reg          o_s_rvalid,
	output reg  [31:0]  o_s_rdata,
	output reg  [1:0]   o_s_rresp,
	input  wire         i_s_rready,
	// motor side inputs
	input  wire [1:0]   i_pulse_source_config,
	input  wire [W-1:0] i_backemf_pulse_threshold,
	input  wire [W-1:0] i_align_angle,
	input  wire         i_fault,
	input  wire         i_pulse_raw,
	input  wire [W-1:0] i_back_emf,
	input  wire         i_brake_pin,
	input  wire [W-1:0] i_comm_angle,
	input  wire [W-1:0] i_speed_analog,
	input  wire [W-1:0] i_speed_duty,
	input  wire [W-1:0] i_speed_digital,
	input  wire [W-1:0] i_speed_freq,
	// motor side outputs
	output wire         o_speed_pulse_output,
	output wire         o_brake_request,
	output wire         o_align_brake,
	output wire [W-1:0] o_brake_angle,
	output wire [W-1:0] o_speed_cmd,
	output reg  [31:0]  o_device_config_one,
	output reg  [14:0]  o_unlock_key
);

	reg  [31:0] pin_cfg_q;
	reg  [31:0] pin_cfg_d;
	reg  [31:0] dev_cfg_d;
	reg  [31:0] rdata_d;
	reg         rd_hit;

	// write taken only with both channels present, one at a time
	wire wr_go = i_s_awvalid && i_s_wvalid && !o_s_awready && !o_s_bvalid;
	wire rd_go = i_s_arvalid && !o_s_arready && !o_s_rvalid;
	wire wr_en = o_s_awready;
	// low two address bits ignored: every register is one aligned word
	wire wr_pin = ({i_s_awaddr[11:2], 2'h0} == `PIN_CFG_ADDR);
	wire wr_dev = ({i_s_awaddr[11:2], 2'h0} == `DEV_CFG1_ADDR); // [RL6]

	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer      k;
		begin
			merge = old_v;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = new_v[k*8 +: 8];
		end
	endfunction

	always @* begin
		pin_cfg_d = merge(pin_cfg_q, i_s_wdata, i_s_wstrb);
		dev_cfg_d = merge(o_device_config_one, i_s_wdata, i_s_wstrb);
		dev_cfg_d[`DEV_CFG1_RSVD_BIT] = 1'b0; // [RL8]
	end

	always @* begin
		rd_hit  = 1'b1;
		rdata_d = 32'h00000000;
		case ({i_s_araddr[11:2], 2'h0})
		`PIN_CFG_ADDR:  rdata_d = pin_cfg_q;
		`DEV_CFG1_ADDR: rdata_d = o_device_config_one & `DEV_CFG1_RD_MASK; // [RL7] [RL8]
		default:             rd_hit  = 1'b0;
		endcase
	end

	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_awready         <= 1'b0;
			o_s_wready          <= 1'b0;
			o_s_bvalid          <= 1'b0;
			o_s_bresp           <= `AXI_RESP_OKAY;
			o_s_arready         <= 1'b0;
			o_s_rvalid          <= 1'b0;
			o_s_rdata           <= 32'h00000000;
			o_s_rresp           <= `AXI_RESP_OKAY;
			pin_cfg_q           <= `PIN_CFG_RESET;
			o_device_config_one <= `DEV_CFG1_RESET; // [RL6]
			o_unlock_key        <= 15'h0000;
		end else begin
			o_s_awready <= wr_go;
			o_s_wready  <= wr_go;
			if (wr_en) begin
				o_s_bvalid <= 1'b1;
				o_s_bresp  <= (wr_pin || wr_dev) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				if (wr_pin)
					pin_cfg_q <= pin_cfg_d;
				if (wr_dev) begin
					o_device_config_one <= dev_cfg_d;
					// key is write-only; kept for the eeprom guard
					o_unlock_key <= dev_cfg_d[`DEV_CFG1_KEY_HI:`DEV_CFG1_KEY_LO];
				end
			end else if (i_s_bready) begin
				o_s_bvalid <= 1'b0;
			end
			o_s_arready <= rd_go;
			if (rd_go) begin
				o_s_rvalid <= 1'b1;
				o_s_rdata  <= rdata_d;
				o_s_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			end else if (i_s_rready && !o_s_arready) begin
				o_s_rvalid <= 1'b0;
			end
		end
	end

	pin_behaviour_logic #(
		.W           (W),
		.DEFAULT_THR (DEFAULT_THR)
	) u_behaviour (
		.i_core_clk                (i_core_clk),
		.i_rst                     (i_rst),
		.i_pin_cfg                 (pin_cfg_q),
		.i_pulse_source_config     (i_pulse_source_config),
		.i_backemf_pulse_threshold (i_backemf_pulse_threshold),
		.i_align_angle             (i_align_angle),
		.i_fault                   (i_fault),
		.i_pulse_raw               (i_pulse_raw),
		.i_back_emf                (i_back_emf),
		.i_brake_pin               (i_brake_pin),
		.i_comm_angle              (i_comm_angle),
		.i_speed_analog            (i_speed_analog),
		.i_speed_duty              (i_speed_duty),
		.i_speed_digital           (i_speed_digital),
		.i_speed_freq              (i_speed_freq),
		.o_speed_pulse_output      (o_speed_pulse_output),
		.o_brake_request           (o_brake_request),
		.o_align_brake             (o_align_brake),
		.o_brake_angle             (o_brake_angle),
		.o_speed_cmd               (o_speed_cmd)
	);

endmodule

// File: rtl/pin_cfg_defines.vh
`ifndef PIN_CFG_DEFINES_VH
`define PIN_CFG_DEFINES_VH

// register indices; byte address is four times the index
`define PIN_CFG_IDX          8'ha4
`define DEV_CFG1_IDX         8'ha6
`define PIN_CFG_ADDR         12'h290
`define DEV_CFG1_ADDR        12'h298
`define PIN_CFG_RESET        32'h00000000
`define DEV_CFG1_RESET       32'h00000000

// pin behaviour fields
`define FAULT_PULSE_HI       8
`define FAULT_PULSE_LO       7
`define BRAKE_MODE_BIT       5
`define ANGLE_SEL_BIT        4
`define BRAKE_SRC_HI         3
`define BRAKE_SRC_LO         2
`define SPEED_SRC_HI         1
`define SPEED_SRC_LO         0

// fault pulse behaviour codes
`define FAULT_KEEP_LAST      2'h0
`define FAULT_FORCE_HIGH     2'h1
`define FAULT_FORCE_LOW      2'h2
`define FAULT_UNTIL_BACK_EMF     2'h3

// brake source codes
`define BRAKE_FROM_PIN       2'h0
`define BRAKE_FORCED         2'h1
`define BRAKE_NEVER          2'h2
`define BRAKE_FROM_PIN_ALT   2'h3

// speed source codes
`define SPEED_ANALOG         2'h0
`define SPEED_DUTY           2'h1
`define SPEED_DIGITAL        2'h2
`define SPEED_FREQ           2'h3

// pulse source code that selects the programmed threshold
`define PULSE_SRC_THR        2'h1

// device config one: write-only key and reserved bit
`define DEV_CFG1_KEY_HI      19
`define DEV_CFG1_KEY_LO      5
`define DEV_CFG1_RSVD_BIT    30
`define DEV_CFG1_RD_MASK     32'hbff0001f

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// File: rtl/pin_behaviour_logic.v
`timescale 1ns/1ps
`include "pin_cfg_defines.vh"

module pin_behaviour_logic #(
	parameter W           = 16,
	parameter DEFAULT_THR = 16'h0100
) (
	// clock and reset
	input  wire         i_core_clk,
	input  wire         i_rst,
	// configuration
	input  wire [31:0]  i_pin_cfg,
	input  wire [1:0]   i_pulse_source_config,
	input  wire [W-1:0] i_backemf_pulse_threshold,
	input  wire [W-1:0] i_align_angle,
	// motor state
	input  wire         i_fault,
	input  wire         i_pulse_raw,
	input  wire [W-1:0] i_back_emf,
	input  wire         i_brake_pin,
	input  wire [W-1:0] i_comm_angle,
	input  wire [W-1:0] i_speed_analog,
	input  wire [W-1:0] i_speed_duty,
	input  wire [W-1:0] i_speed_digital,
	input  wire [W-1:0] i_speed_freq,
	// results
	output reg          o_speed_pulse_output,
	output reg          o_brake_request,
	output reg          o_align_brake,
	output reg  [W-1:0] o_brake_angle,
	output reg  [W-1:0] o_speed_cmd
);

	wire [1:0]   fault_mode = i_pin_cfg[`FAULT_PULSE_HI:`FAULT_PULSE_LO];
	wire [1:0]   brake_src  = i_pin_cfg[`BRAKE_SRC_HI:`BRAKE_SRC_LO];
	wire [1:0]   speed_src  = i_pin_cfg[`SPEED_SRC_HI:`SPEED_SRC_LO];
	wire         brake_mode = i_pin_cfg[`BRAKE_MODE_BIT];
	wire         angle_sel  = i_pin_cfg[`ANGLE_SEL_BIT];
	wire [W-1:0] thr        = (i_pulse_source_config == `PULSE_SRC_THR) ?
	                          i_backemf_pulse_threshold : DEFAULT_THR;

	reg          last_pulse_q;
	reg          back_emf_low_q;
	reg          brake_req_d;
	reg          pulse_d;
	reg  [W-1:0] speed_d;
	reg  [W-1:0] last_angle_q;

	// once back-emf has fallen below threshold the pulse stays quiet till fault ends
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			last_pulse_q <= 1'b0;
			back_emf_low_q   <= 1'b0;
		end else begin
			if (!i_fault)
				last_pulse_q <= i_pulse_raw;
			if (!i_fault)
				back_emf_low_q <= 1'b0;
			else if (i_back_emf < thr)
				back_emf_low_q <= 1'b1; // [RL2]
		end
	end

	always @* begin
		pulse_d = i_pulse_raw;
		if (i_fault) begin
			case (fault_mode) // [RL1]
			`FAULT_KEEP_LAST:  pulse_d = last_pulse_q;
			`FAULT_FORCE_HIGH: pulse_d = 1'b1;
			`FAULT_FORCE_LOW:  pulse_d = 1'b0;
			`FAULT_UNTIL_BACK_EMF: pulse_d = (back_emf_low_q || i_back_emf < thr) ? 1'b0 : i_pulse_raw; // [RL2]
			default:           pulse_d = last_pulse_q;
			endcase
		end
	end

	always @* begin
		case (brake_src) // [RL3]
		`BRAKE_FORCED: brake_req_d = 1'b1;
		`BRAKE_NEVER:  brake_req_d = 1'b0;
		default:       brake_req_d = i_brake_pin;
		endcase
	end

	always @* begin
		case (speed_src) // [RL5]
		`SPEED_ANALOG:  speed_d = i_speed_analog;
		`SPEED_DUTY:    speed_d = i_speed_duty;
		`SPEED_DIGITAL: speed_d = i_speed_digital;
		`SPEED_FREQ:    speed_d = i_speed_freq;
		default:        speed_d = i_speed_analog;
		endcase
	end

	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_speed_pulse_output <= 1'b0;
			o_brake_request      <= 1'b0;
			o_align_brake        <= 1'b0;
			o_brake_angle        <= {W{1'b0}};
			o_speed_cmd          <= {W{1'b0}};
			last_angle_q         <= {W{1'b0}};
		end else begin
			o_speed_pulse_output <= pulse_d;
			o_brake_request      <= brake_req_d;
			o_align_brake        <= brake_req_d & brake_mode; // [RL3]
			o_speed_cmd          <= speed_d;
			// angle frozen at the moment braking begins
			if (!o_brake_request)
				last_angle_q <= i_comm_angle; // [RL4]
			o_brake_angle <= angle_sel ? i_align_angle :
			                 (o_brake_request ? last_angle_q : i_comm_angle); // [RL4]
		end
	end

endmodule

// File: dv/cfg_checker_assertions.sv
`timescale 1ns/1ps
module cfg_checker (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        o_s_awready,
	input wire logic [11:0] i_s_awaddr,
	input wire logic [31:0] i_s_wdata,
	input wire logic        o_s_bvalid,
	input wire logic        o_s_rvalid,
	input wire logic        i_s_rready,
	input wire logic        i_fault,
	input wire logic        i_pulse_raw,
	input wire logic        i_brake_pin,
	input wire logic        o_speed_pulse_output,
	input wire logic        o_brake_request,
	input wire logic        o_align_brake
);
	logic [8:0] cfg_q;
	wire  [1:0] fm = cfg_q[8:7];
	wire  [1:0] bs = cfg_q[3:2];
	// shadow of the low fields; assumes full strobes on this register
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			cfg_q <= 9'h000;
		else if (o_s_awready && i_s_awaddr[11:2] == 10'ha4)
			cfg_q <= i_s_wdata[8:0];
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_fault_high; i_fault && fm == 2'h1 |=> o_speed_pulse_output; endproperty
	a_fault_high: assert property (p_fault_high) else $error("pulse not high");
	property p_fault_low; i_fault && fm == 2'h2 |=> !o_speed_pulse_output; endproperty
	a_fault_low: assert property (p_fault_low) else $error("pulse not low");
	property p_keep_last;
		i_fault && !$past(i_fault) && fm == 2'h0 |=> o_speed_pulse_output == $past(o_speed_pulse_output);
	endproperty
	a_keep_last: assert property (p_keep_last) else $error("pulse not held");
	property p_no_fault; !i_fault |=> o_speed_pulse_output == $past(i_pulse_raw); endproperty
	a_no_fault: assert property (p_no_fault) else $error("pulse not following");
	property p_brake_pin;
		bs == 2'h0 || bs == 2'h3 |=> o_brake_request == $past(i_brake_pin);
	endproperty
	a_brake_pin: assert property (p_brake_pin) else $error("brake not from pin");
	property p_brake_forced;
		bs == 2'h1 |=> o_brake_request && o_align_brake == $past(cfg_q[5]);
	endproperty
	a_brake_forced: assert property (p_brake_forced) else $error("forced brake");
	property p_brake_never; bs == 2'h2 |=> !o_brake_request && !o_align_brake; endproperty
	a_brake_never: assert property (p_brake_never) else $error("brake not off");
	property p_wr_resp; o_s_awready |=> o_s_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	property p_r_hold; o_s_rvalid && !i_s_rready |=> o_s_rvalid; endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	c_read: cover property (o_s_rvalid && i_s_rready);
	c_force: cover property (bs == 2'h1 && cfg_q[5]);
	c_low: cover property (i_fault && fm == 2'h2);
endmodule
bind motor_pin_device_config_regs cfg_checker u_cfg_checker (.i_core_clk, .i_rst,
	.o_s_awready, .i_s_awaddr, .i_s_wdata, .o_s_bvalid, .o_s_rvalid, .i_s_rready, .i_fault,
	.i_pulse_raw, .i_brake_pin, .o_speed_pulse_output, .o_brake_request, .o_align_brake);

// File: dv/motor_side_model.sv
`timescale 1ns/1ps
module motor_side_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	output wire logic        o_pulse,
	output wire logic        o_brake_pin,
	output wire logic [15:0] o_angle,
	output wire logic [15:0] o_back_emf
);
	logic [7:0] cnt_q;
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
	end
	assign o_pulse     = cnt_q[1];
	assign o_brake_pin = cnt_q[3];
	// angle moves every cycle so a frozen latch is visible
	assign o_angle     = {cnt_q, 8'h5a};
	// short sawtooth: back-emf sweeps below any nonzero threshold in 64 cycles
	assign o_back_emf  = {cnt_q[5:0], 10'h000};
endmodule

// File: dv/motor_pin_device_config_regs_tb.sv
`timescale 1ns/1ps
`include "pin_cfg_defines.vh"
module motor_pin_device_config_regs_tb;
	logic        i_core_clk = 1'h0, i_rst = 1'h1, i_fault = 1'h0;
	logic        i_s_awvalid = 1'h0, i_s_wvalid = 1'h0, i_s_bready = 1'h0;
	logic        i_s_arvalid = 1'h0, i_s_rready = 1'h0;
	logic [11:0] i_s_awaddr = 12'h0, i_s_araddr = 12'h0;
	logic [31:0] i_s_wdata = 32'h0, d;
	logic [3:0]  i_s_wstrb = 4'hf;
	logic [1:0]  i_pulse_source_config = 2'h0;
	logic [15:0] i_backemf_pulse_threshold = 16'h0, i_align_angle = 16'h0, a;
	logic [15:0] sp [4];
	wire         o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid;
	wire         i_pulse_raw, i_brake_pin, o_speed_pulse_output, o_brake_request, o_align_brake;
	wire  [1:0]  o_s_bresp, o_s_rresp;
	wire  [31:0] o_s_rdata, o_device_config_one;
	wire  [15:0] i_back_emf, i_comm_angle, o_brake_angle, o_speed_cmd;
	wire  [14:0] o_unlock_key;
	logic [33:0] q [$];
	int          seed, i, num_errors = 0, comparisons = 0;
	motor_pin_device_config_regs u_motor_pin_device_config_regs (.i_core_clk, .i_rst,
		.i_s_awvalid, .i_s_awaddr, .o_s_awready, .i_s_wvalid, .i_s_wdata, .i_s_wstrb,
		.o_s_wready, .o_s_bvalid, .o_s_bresp, .i_s_bready, .i_s_arvalid, .i_s_araddr,
		.o_s_arready, .o_s_rvalid, .o_s_rdata, .o_s_rresp, .i_s_rready, .i_pulse_source_config,
		.i_backemf_pulse_threshold, .i_align_angle, .i_fault, .i_pulse_raw, .i_back_emf,
		.i_brake_pin, .i_comm_angle, .i_speed_analog(sp[0]), .i_speed_duty(sp[1]),
		.i_speed_digital(sp[2]), .i_speed_freq(sp[3]), .o_speed_pulse_output,
		.o_brake_request, .o_align_brake, .o_brake_angle, .o_speed_cmd,
		.o_device_config_one, .o_unlock_key);
	motor_side_model u_motor_side_model (.i_core_clk, .i_rst, .o_pulse(i_pulse_raw),
		.o_brake_pin(i_brake_pin), .o_angle(i_comm_angle), .o_back_emf(i_back_emf));
	initial forever #2.5 i_core_clk = ~i_core_clk;
	task check(input [33:0] seen, input [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input [11:0] ad, input [31:0] dt, input [1:0] rsp);
		@(posedge i_core_clk);
		i_s_awaddr <= ad;
		i_s_wdata <= dt;
		i_s_awvalid <= 1'h1;
		i_s_wvalid <= 1'h1;
		i_s_bready <= 1'h1;
		do @(posedge i_core_clk); while (o_s_awready !== 1'h1);
		i_s_awvalid <= 1'h0;
		i_s_wvalid <= 1'h0;
		do @(posedge i_core_clk); while (o_s_bvalid !== 1'h1);
		i_s_bready <= 1'h0;
		check(o_s_bresp, rsp);
	endtask
	// rready raised only after the address is taken; read data pairs with the queued note
	task rd(input [11:0] ad, input [33:0] exp);
		@(posedge i_core_clk);
		i_s_araddr <= ad;
		i_s_arvalid <= 1'h1;
		q.push_back(exp);
		do @(posedge i_core_clk); while (o_s_arready !== 1'h1);
		i_s_arvalid <= 1'h0;
		i_s_rready <= 1'h1;
		do @(posedge i_core_clk); while (o_s_rvalid !== 1'h1);
		i_s_rready <= 1'h0;
	endtask
	always @(posedge i_core_clk) begin
		if (o_s_rvalid === 1'h1 && i_s_rready === 1'h1)
			check({o_s_rresp, o_s_rdata}, q.pop_front());
	end
	initial begin
		seed = 89;
		for (i = 0; i < 4; i++)
			sp[i] = $random(seed);
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'h0;
		i_align_angle <= $random(seed);
		i_backemf_pulse_threshold <= 16'h8000;
		rd(`DEV_CFG1_ADDR, {`AXI_RESP_OKAY, `DEV_CFG1_RESET});
		rd(`PIN_CFG_ADDR, {`AXI_RESP_OKAY, `PIN_CFG_RESET});
		for (i = 0; i < 4; i++) begin
			wr(`PIN_CFG_ADDR, i, `AXI_RESP_OKAY);
			repeat (2) @(posedge i_core_clk);
			check(o_speed_cmd, sp[i]);
		end
		for (i = 0; i < 8; i++) begin
			wr(`PIN_CFG_ADDR, {i[2], 1'h0, i[1:0], 2'h0}, `AXI_RESP_OKAY);
			repeat (2) @(posedge i_core_clk);
			if (i[1:0] == 2'h1 || i[1:0] == 2'h2)
				check({o_brake_request, o_align_brake}, {i[1:0] == 2'h1, i[2] && i[0]});
		end
		wr(`PIN_CFG_ADDR, 32'h14, `AXI_RESP_OKAY);
		repeat (2) @(posedge i_core_clk);
		check(o_brake_angle, i_align_angle);
		wr(`PIN_CFG_ADDR, 32'h04, `AXI_RESP_OKAY);
		repeat (2) @(posedge i_core_clk);
		a = o_brake_angle;
		repeat (3) @(posedge i_core_clk);
		check(o_brake_angle, a);
		for (i = 0; i < 3; i++) begin
			wr(`PIN_CFG_ADDR, i << 7, `AXI_RESP_OKAY);
			i_fault <= 1'h1;
			repeat (2) @(posedge i_core_clk);
			a[0] = o_speed_pulse_output;
			@(posedge i_core_clk);
			if (i != 0)
				check(o_speed_pulse_output, i == 1);
			else
				check(o_speed_pulse_output, a[0]);
			i_fault <= 1'h0;
		end
		i_pulse_source_config <= 2'h1;
		wr(`PIN_CFG_ADDR, 32'h180, `AXI_RESP_OKAY);
		i_fault <= 1'h1;
		repeat (70) @(posedge i_core_clk);
		check(o_speed_pulse_output, 1'h0);
		i_fault <= 1'h0;
		d = $random(seed);
		wr(`DEV_CFG1_ADDR, d, `AXI_RESP_OKAY);
		rd(`DEV_CFG1_ADDR, {`AXI_RESP_OKAY, d & `DEV_CFG1_RD_MASK});
		check(o_unlock_key, d[19:5]);
		check(o_device_config_one, d & 32'hbfffffff);
		wr(12'h100, d, `AXI_RESP_SLVERR);
		rd(12'h100, {`AXI_RESP_SLVERR, 32'h0});
		repeat (2) @(posedge i_core_clk);
		print_verdict;
	end
	initial begin
		#50000;
		num_errors++;
		print_verdict;
	end
endmodule
